/* rtl/nsrc_select.sv */
// Command-source selector for network operation of a motor drive.
// Assumes all inputs are synchronous to I_REF_CLK; the serial link decoder is outside.
// Behaviour
// - Run source: 0 network, 1 terminals.
// - Speed source: 0 network, 1 or 2 terminals.
// - External-only functions ignore network commands.
// - Network-only functions ignore terminal inputs.
// - Combined functions honour terminal and network.
// - Invalid functions ignore both sources.
// - Output stop becomes interlock in mode 7 unless a terminal is coded 12 (interlock).
// - Network source follows comm source selection.
// - Mode-2 writes while running apply after stop.
// - Source switch toggles start and speed sources.
// - Switch active only on terminals coded 67.
// - Switch off forces terminal start and speed.
// - Switch unassigned or on follows selections.
// - Switch changes apply only while stopped.
// - Switch off rejects network reset requests.
// - Host commands over serial link are served.
`include "nsrc_defines.svh"
module nsrc_select
	import nsrc_pkg::*;
(
	input  wire logic                                      I_REF_CLK,
	input  wire logic                                      I_RESETN,
	input  wire logic                                      I_NET_MODE,
	input  wire logic                                      I_STOPPED,
	input  wire logic                                      I_PARAM_WR,
	input  wire logic                                      I_RUN_SRC_SEL,
	input  wire logic [1:0]                                I_SPEED_SRC_SEL,
	input  wire logic [1:0]                                I_PARAM_WRITE_SEL,
	input  wire logic [3:0]                                I_OP_MODE_SEL,
	input  wire logic [1:0]                                I_COMM_SRC_SEL,
	input  wire logic [`NSRC_TERM_N*`NSRC_FUNC_W-1:0]      I_INPUT_FUNC_SEL,
	input  wire logic [`NSRC_TERM_N-1:0]                   I_TERM_LEVEL,
	input  wire logic                                      I_TERM_START_CMD,
	input  wire logic                                      I_NET_START_CMD,
	input  wire logic                                      I_TERM_JOG_CMD,
	input  wire logic                                      I_NET_JOG_CMD,
	input  wire logic                                      I_TERM_STOP_CMD,
	input  wire logic                                      I_NET_STOP_CMD,
	input  wire logic                                      I_TERM_RESET_REQ,
	input  wire logic                                      I_NET_RESET_REQ,
	input  wire logic [`NSRC_SPEED_W-1:0]                  I_TERM_SPEED,
	input  wire logic [`NSRC_SPEED_W-1:0]                  I_NET_SPEED,
	output logic                                           O_START_CMD,
	output logic                                           O_JOG_CMD,
	output logic                                           O_OUTPUT_STOP,
	output logic                                           O_PANEL_INTERLOCK,
	output logic                                           O_RESET_REQ,
	output logic [`NSRC_SPEED_W-1:0]                       O_SPEED_CMD,
	output logic                                           O_START_FROM_NET,
	output logic                                           O_SPEED_FROM_NET,
	output logic [1:0]                                     O_COMM_SRC,
	output logic                                           O_WRITE_REJECT
);
	logic                     sw_assigned;
	logic                     sw_on;
	logic                     il_assigned;
	logic                     wr_ok;
	logic                     run_pend_reg,  run_pend_next;
	logic [1:0]               spd_pend_reg,  spd_pend_next;
	logic                     sw_on_reg,     sw_on_next;
	logic                     start_net_reg, start_net_next;
	logic                     speed_net_reg, speed_net_next;
	logic                     interlock_role;
	nsrc_route_e              route [`NSRC_NFUNC];
	logic [`NSRC_NFUNC-1:0]   term_cmd;
	logic [`NSRC_NFUNC-1:0]   net_cmd;
	logic [`NSRC_NFUNC-1:0]   cmd;
	logic                     start_q_next, jog_q_next, stop_q_next, il_q_next, reset_q_next;
	logic [`NSRC_SPEED_W-1:0] speed_q_next;
	logic                     wr_rej_next;
	logic [1:0]               comm_src_next;

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESETN);

	// Find which terminals carry the source switch and the panel interlock.
	always_comb begin
		sw_assigned = 1'b0;
		sw_on       = 1'b0;
		il_assigned = 1'b0;
		for (int t = 0; t < `NSRC_TERM_N; t++) begin
			if (I_INPUT_FUNC_SEL[t*`NSRC_FUNC_W +: `NSRC_FUNC_W] == `NSRC_FUNC_SWITCH) begin
				sw_assigned = 1'b1;
				sw_on       = sw_on | I_TERM_LEVEL[t];
			end
			if (I_INPUT_FUNC_SEL[t*`NSRC_FUNC_W +: `NSRC_FUNC_W] == `NSRC_FUNC_INTERLOCK) begin
				il_assigned = 1'b1;
			end
		end
	end

	// Selection writes, taken while running in mode 2 only, and the effective sources, frozen while running.
	always_comb begin
		wr_ok          = I_STOPPED || (I_PARAM_WRITE_SEL == `NSRC_PWS_RUN_WRITE);
		run_pend_next  = run_pend_reg;
		spd_pend_next  = spd_pend_reg;
		if (I_PARAM_WR && wr_ok) begin
			run_pend_next = I_RUN_SRC_SEL;
			spd_pend_next = I_SPEED_SRC_SEL;
		end
		sw_on_next     = sw_on_reg;
		start_net_next = start_net_reg;
		speed_net_next = speed_net_reg;
		if (I_STOPPED) begin
			sw_on_next = sw_on;
			if (!I_NET_MODE) begin
				start_net_next = 1'b0;
				speed_net_next = 1'b0;
			end else if (sw_assigned && !sw_on) begin
				start_net_next = 1'b0;
				speed_net_next = 1'b0;
			end else begin
				start_net_next = (run_pend_reg == `NSRC_RUN_SRC_NET);
				speed_net_next = (spd_pend_reg == `NSRC_SPEED_SRC_NET);
			end
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			run_pend_reg  <= `NSRC_RST_RUN_SRC;
			spd_pend_reg  <= `NSRC_RST_SPEED_SRC;
			sw_on_reg     <= 1'b0;
			start_net_reg <= 1'b0;
			speed_net_reg <= 1'b0;
		end else begin
			run_pend_reg  <= run_pend_next;
			spd_pend_reg  <= spd_pend_next;
			sw_on_reg     <= sw_on_next;
			start_net_reg <= start_net_next;
			speed_net_reg <= speed_net_next;
		end
	end

	// Source class of each gated function.
	always_comb begin
		interlock_role = (I_OP_MODE_SEL == `NSRC_OPMODE_INTERLOCK) && !il_assigned;
		route[`NSRC_IDX_START] = start_net_reg ? NSRC_ROUTE_NET : NSRC_ROUTE_EXT;
		route[`NSRC_IDX_JOG]   = start_net_reg ? NSRC_ROUTE_NONE : NSRC_ROUTE_EXT;
		if (interlock_role || !start_net_reg) begin
			route[`NSRC_IDX_STOP] = NSRC_ROUTE_EXT;
		end else begin
			route[`NSRC_IDX_STOP] = NSRC_ROUTE_COMB;
		end
		// A held-off switch blocks resets from the link.
		if (sw_assigned && !sw_on_reg) begin
			route[`NSRC_IDX_RESET] = NSRC_ROUTE_EXT;
		end else begin
			route[`NSRC_IDX_RESET] = NSRC_ROUTE_COMB;
		end
	end

	assign term_cmd = {I_TERM_RESET_REQ, I_TERM_STOP_CMD, I_TERM_JOG_CMD, I_TERM_START_CMD};
	assign net_cmd  = {I_NET_RESET_REQ, I_NET_STOP_CMD, I_NET_JOG_CMD, I_NET_START_CMD};

	for (genvar f = 0; f < `NSRC_NFUNC; f++) begin : g_func
		nsrc_route u_route (
			.i_route (route[f]),
			.i_term  (term_cmd[f]),
			.i_net   (net_cmd[f]),
			.o_cmd   (cmd[f])
		);
	end

	// Output values; network commands are those decoded from the host link.
	always_comb begin
		start_q_next  = cmd[`NSRC_IDX_START];
		jog_q_next    = cmd[`NSRC_IDX_JOG];
		stop_q_next   = interlock_role ? 1'b0 : cmd[`NSRC_IDX_STOP];
		il_q_next     = interlock_role ? cmd[`NSRC_IDX_STOP] : 1'b0;
		reset_q_next  = cmd[`NSRC_IDX_RESET];
		speed_q_next  = speed_net_reg ? I_NET_SPEED : I_TERM_SPEED;
		wr_rej_next   = I_PARAM_WR && !wr_ok;
		comm_src_next = I_COMM_SRC_SEL;
	end

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_START_CMD       <= 1'b0;
			O_JOG_CMD         <= 1'b0;
			O_OUTPUT_STOP     <= 1'b0;
			O_PANEL_INTERLOCK <= 1'b0;
			O_RESET_REQ       <= 1'b0;
			O_SPEED_CMD       <= '0;
			O_START_FROM_NET  <= 1'b0;
			O_SPEED_FROM_NET  <= 1'b0;
			O_COMM_SRC        <= 2'h0;
			O_WRITE_REJECT    <= 1'b0;
		end else begin
			O_START_CMD       <= start_q_next;
			O_JOG_CMD         <= jog_q_next;
			O_OUTPUT_STOP     <= stop_q_next;
			O_PANEL_INTERLOCK <= il_q_next;
			O_RESET_REQ       <= reset_q_next;
			O_SPEED_CMD       <= speed_q_next;
			O_START_FROM_NET  <= start_net_reg;
			O_SPEED_FROM_NET  <= speed_net_reg;
			O_COMM_SRC        <= comm_src_next;
			O_WRITE_REJECT    <= wr_rej_next;
		end
	end

	sequence s_write_running;
		I_PARAM_WR && !I_STOPPED && (I_PARAM_WRITE_SEL == `NSRC_PWS_RUN_WRITE);
	endsequence
	sequence s_stop_net_terms;
		I_STOPPED && I_NET_MODE && !(sw_assigned && !sw_on);
	endsequence

	AST_EXT_START: assert property (!start_net_reg |=> O_START_CMD == $past(I_TERM_START_CMD))
		else $error("terminal start not followed");
	AST_NET_START: assert property (start_net_reg |=> O_START_CMD == $past(I_NET_START_CMD))
		else $error("network start not followed");
	AST_COMB_STOP: assert property (start_net_reg && !interlock_role
		|=> O_OUTPUT_STOP == ($past(I_TERM_STOP_CMD) | $past(I_NET_STOP_CMD)))
		else $error("combined output stop wrong");
	AST_NONE_JOG: assert property (start_net_reg |=> !O_JOG_CMD)
		else $error("jog accepted while invalid");
	AST_INTERLOCK: assert property (interlock_role
		|=> O_PANEL_INTERLOCK == $past(I_TERM_STOP_CMD) && !O_OUTPUT_STOP)
		else $error("panel interlock routing wrong");
	AST_RUN_WRITE: assert property (s_write_running ##1 !I_STOPPED
		|-> run_pend_reg == $past(I_RUN_SRC_SEL) && $stable(start_net_reg))
		else $error("running write mishandled");
	AST_FOLLOW_SEL: assert property (s_stop_net_terms
		|=> start_net_reg == ($past(run_pend_reg) == `NSRC_RUN_SRC_NET)
		&& speed_net_reg == ($past(spd_pend_reg) == `NSRC_SPEED_SRC_NET))
		else $error("sources do not follow selections");
	AST_SWITCH_OFF: assert property (I_STOPPED && sw_assigned && !sw_on
		|=> !start_net_reg ##1 !O_START_FROM_NET && !O_SPEED_FROM_NET)
		else $error("switch off did not force terminals");
	AST_HOLD_RUN: assert property (!I_STOPPED |=> $stable(sw_on_reg) && $stable(speed_net_reg))
		else $error("sources changed while running");
	AST_RESET_REJ: assert property (sw_assigned && !sw_on_reg && !I_TERM_RESET_REQ
		|=> !O_RESET_REQ)
		else $error("network reset accepted with switch off");
	AST_SPEED_SRC: assert property (speed_net_reg |=> O_SPEED_CMD == $past(I_NET_SPEED))
		else $error("network speed not followed");
endmodule

/* pkg/nsrc_defines.svh */
// Constants for the network command-source selector.
// Assumes inclusion by the selector package and design files only.
`ifndef NSRC_DEFINES_SVH
`define NSRC_DEFINES_SVH
`define NSRC_RUN_SRC_NET      1'h0
`define NSRC_SPEED_SRC_NET    2'h0
`define NSRC_PWS_RUN_WRITE    2'h2
`define NSRC_OPMODE_INTERLOCK 4'h7
`define NSRC_FUNC_SWITCH      7'h43
`define NSRC_FUNC_INTERLOCK   7'h0C
`define NSRC_FUNC_W           7
`define NSRC_TERM_N           5
`define NSRC_SPEED_W          16
`define NSRC_NFUNC            4
`define NSRC_IDX_START        0
`define NSRC_IDX_JOG          1
`define NSRC_IDX_STOP         2
`define NSRC_IDX_RESET        3
`define NSRC_RST_RUN_SRC      1'h0
`define NSRC_RST_SPEED_SRC    2'h0
`endif

/* pkg/nsrc_pkg.sv */
// Types for the network command-source selector.
// Assumes the constants header is on the include path.
`include "nsrc_defines.svh"
package nsrc_pkg;
	typedef enum logic [1:0] {
		NSRC_ROUTE_EXT,
		NSRC_ROUTE_NET,
		NSRC_ROUTE_COMB,
		NSRC_ROUTE_NONE
	} nsrc_route_e;
endpackage

/* rtl/nsrc_route.sv */
// One command function gated by its source class.
// Assumes the class and both command levels are already synchronous.
module nsrc_route
	import nsrc_pkg::*;
(
	input  wire nsrc_route_e i_route,
	input  wire logic        i_term,
	input  wire logic        i_net,
	output logic             o_cmd
);
	always_comb begin
		case (i_route)
			NSRC_ROUTE_EXT:  o_cmd = i_term;
			NSRC_ROUTE_NET:  o_cmd = i_net;
			NSRC_ROUTE_COMB: o_cmd = i_term | i_net;
			default:         o_cmd = 1'b0;
		endcase
	end
endmodule

/* test/nsrc_host_model.sv */
// Host-side model of the serial link: decoded network commands and speed.
// Assumes the bench sets the host requests at the falling clock edge.
module nsrc_host_model (
	input  wire logic        i_link_up,
	input  wire logic [3:0]  i_cmd,
	input  wire logic [15:0] i_speed,
	output logic      [3:0]  o_cmd,
	output logic      [15:0] o_speed
);
	timeunit 1ns;
	timeprecision 100ps;
	// A silent link carries no command and the inverted requested speed word.
	assign o_cmd   = i_link_up ? i_cmd : 4'h0;
	assign o_speed = i_link_up ? i_speed : ~i_speed;
endmodule

/* test/test_nsrc_select.sv */
// Self-checking bench for the command-source selector.
// Assumes the host model file is compiled first.
module test_nsrc_select;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rstn, nmode, stopped, pwr, run_sel, rej, link;
	logic [1:0] spd_sel, pws, comm, o_comm;
	logic [3:0] opm, tcmd, nreq;
	logic [34:0] fsel;
	logic [4:0] tlev;
	logic [15:0] tspd, nreq_spd, o_spd;
	wire [3:0] ncmd;
	wire [15:0] nspd;
	logic o_start, o_jog, o_stop, o_lock, o_rst, o_snet, o_vnet, o_rej;
	int err_total = 0;
	int total_checks = 0;
	logic [7:0] rows [5] = '{8'h13, 8'h0F, 8'hA8, 8'hD4, 8'h5E};
	nsrc_host_model i_nsrc_host_model (.i_link_up(link), .i_cmd(nreq), .i_speed(nreq_spd),
		.o_cmd(ncmd), .o_speed(nspd));
	nsrc_select i_nsrc_select (.I_REF_CLK(clk), .I_RESETN(rstn), .I_NET_MODE(nmode),
		.I_STOPPED(stopped), .I_PARAM_WR(pwr), .I_RUN_SRC_SEL(run_sel),
		.I_SPEED_SRC_SEL(spd_sel), .I_PARAM_WRITE_SEL(pws), .I_OP_MODE_SEL(opm),
		.I_COMM_SRC_SEL(comm), .I_INPUT_FUNC_SEL(fsel), .I_TERM_LEVEL(tlev),
		.I_TERM_START_CMD(tcmd[0]), .I_NET_START_CMD(ncmd[0]), .I_TERM_JOG_CMD(tcmd[1]),
		.I_NET_JOG_CMD(ncmd[1]), .I_TERM_STOP_CMD(tcmd[2]), .I_NET_STOP_CMD(ncmd[2]),
		.I_TERM_RESET_REQ(tcmd[3]), .I_NET_RESET_REQ(ncmd[3]), .I_TERM_SPEED(tspd),
		.I_NET_SPEED(nspd), .O_START_CMD(o_start), .O_JOG_CMD(o_jog),
		.O_OUTPUT_STOP(o_stop), .O_PANEL_INTERLOCK(o_lock), .O_RESET_REQ(o_rst),
		.O_SPEED_CMD(o_spd), .O_START_FROM_NET(o_snet), .O_SPEED_FROM_NET(o_vnet),
		.O_COMM_SRC(o_comm), .O_WRITE_REJECT(o_rej));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Reject is sampled over the two cycles after the write pulse.
	task automatic wr(input logic r, input logic [1:0] s);
		@(negedge clk);
		pwr = 1'b1;
		run_sel = r;
		spd_sel = s;
		@(negedge clk);
		pwr = 1'b0;
		rej = o_rej;
		@(negedge clk);
		rej = rej | o_rej;
	endtask
	task automatic close_out();
		if (err_total == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		close_out();
	end
	initial begin
		{rstn, pwr, run_sel, spd_sel, pws, opm, fsel, tlev, tcmd, nreq} = '0;
		{link, nmode, stopped, comm} = {1'b1, 1'b1, 1'b1, 2'h1};
		{tspd, nreq_spd} = {16'h1234, 16'h5678};
		step(10);
		chk("rst start_from_net", 16'h0, o_snet);
		step(6);
		rstn = 1'b1;
		foreach (rows[i]) begin
			wr(rows[i][7], rows[i][6:5]);
			tcmd[0] = rows[i][4];
			nreq[0] = rows[i][3];
			step(3);
			chk("start", rows[i][2], o_start);
			chk("start_from_net", rows[i][1], o_snet);
			chk("speed_from_net", rows[i][0], o_vnet);
			chk("speed", rows[i][0] ? 16'h5678 : 16'h1234, o_spd);
		end
		tcmd = 4'h2;
		nreq = 4'h2;
		step(2);
		chk("jog", 16'h0, o_jog);
		tcmd = 4'h0;
		nreq = 4'h4;
		step(2);
		chk("output_stop", 16'h1, o_stop);
		{opm, tcmd, nreq, comm} = {4'h7, 4'h4, 4'h0, 2'h3};
		step(2);
		chk("interlock", 16'h1, o_lock);
		chk("comm_src", 16'h3, o_comm);
		{opm, tcmd, stopped, pws} = {4'h0, 4'h0, 1'b0, 2'h1};
		wr(1'b1, 2'h0);
		chk("reject", 16'h1, rej);
		pws = 2'h2;
		wr(1'b1, 2'h0);
		chk("reject", 16'h0, rej);
		step(3);
		chk("start_from_net running", 16'h1, o_snet);
		stopped = 1'b1;
		step(3);
		chk("start_from_net stopped", 16'h0, o_snet);
		wr(1'b0, 2'h0);
		fsel[6:0] = 7'h43;
		nreq = 4'h8;
		step(3);
		chk("switch off start", 16'h0, o_snet);
		chk("switch off speed", 16'h0, o_vnet);
		chk("net reset", 16'h0, o_rst);
		{stopped, tlev} = {1'b0, 5'h01};
		step(3);
		chk("switch on running", 16'h0, o_snet);
		stopped = 1'b1;
		step(3);
		chk("switch on stopped", 16'h1, o_snet);
		{fsel[6:0], tlev} = {7'h42, 5'h00};
		step(3);
		chk("other code", 16'h1, o_snet);
		nmode = 1'b0;
		step(3);
		chk("non-network start", 16'h0, o_snet);
		{nmode, tcmd, nreq} = {1'b0, 4'hA, 4'h0};
		step(2);
		chk("terminal jog", 16'h1, o_jog);
		chk("terminal reset", 16'h1, o_rst);
		{nmode, tcmd, nreq} = {1'b1, 4'h0, 4'h8};
		step(3);
		chk("net reset honoured", 16'h1, o_rst);
		chk("net speed", 16'h5678, o_spd);
		link = 1'b0;
		step(2);
		chk("link down reset", 16'h0, o_rst);
		chk("link down speed", 16'hA987, o_spd);
		{link, opm, tcmd, nreq, fsel[13:7]} = {1'b1, 4'h7, 4'h4, 4'h0, 7'h0C};
		step(2);
		chk("interlock assigned lock", 16'h0, o_lock);
		chk("interlock assigned stop", 16'h1, o_stop);
		{rstn, stopped} = 2'b00;
		step(2);
		chk("reset stop", 16'h0, o_stop);
		chk("reset speed", 16'h0, o_spd);
		chk("reset comm_src", 16'h0, o_comm);
		rstn = 1'b1;
		step(2);
		chk("reset running start_from_net", 16'h0, o_snet);
		stopped = 1'b1;
		step(3);
		chk("reset stopped start_from_net", 16'h1, o_snet);
		close_out();
	end
endmodule
